// ---- rtl/tmr_pkg.sv ----
package tmr_pkg;
  // data-space register offsets
  localparam logic [7:0] FLAGS_OFS     = 8'h37;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h70;
  localparam logic [7:0] CONTROL_A_OFS = 8'hB0;
  localparam logic [7:0] CONTROL_B_OFS = 8'hB1;
  localparam logic [7:0] COUNT_OFS     = 8'hB2;
  localparam logic [7:0] COMPARE_A_OFS = 8'hB3;
  localparam logic [7:0] COMPARE_B_OFS = 8'hB4;
  // short I/O access window
  localparam logic [7:0] IO_BASE       = 8'h20;
  localparam logic [7:0] IO_LAST       = 8'h3F;
  // field positions
  localparam int FOC_A_BIT   = 7;
  localparam int FOC_B_BIT   = 6;
  localparam int WGM_HI_BIT  = 3;
  localparam int CMP_B_BIT   = 2;
  localparam int CMP_A_BIT   = 1;
  localparam int OVF_BIT     = 0;
  // reset value and counter top value
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  // prescaler taps, as divide-by-n minus one masks
  localparam int PRESCALE_W = 10;
  localparam logic [9:0] DIV8_MASK    = 10'h007;
  localparam logic [9:0] DIV32_MASK   = 10'h01F;
  localparam logic [9:0] DIV64_MASK   = 10'h03F;
  localparam logic [9:0] DIV128_MASK  = 10'h07F;
  localparam logic [9:0] DIV256_MASK  = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;
  // compare output actions
  typedef enum logic [1:0] {
    TMR_COM_OFF    = 2'h0,
    TMR_COM_TOGGLE = 2'h1,
    TMR_COM_CLEAR  = 2'h2,
    TMR_COM_SET    = 2'h3
  } tmr_com_e;
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_CLEAR_MATCH = 3'h2;
endpackage

// ---- rtl/tmr_timer2.sv ----
`timescale 1ns/10ps
// Operation
// - Force strobes act only in non-pwm waveform modes; ignored in pwm.
// - Written force strobe applies compare-match action to that channel output at once.
// - Forced compare sets no flag and does not clear the counter.
// - Force strobe bits always read as zero.
// - Clock select: 0 stopped, 1 every clock, 2 div 8, 3 div 32.
// - Clock select: 4 div 64, 5 div 128, 6 div 256, 7 div 1024.
// - Counter register gives full 8-bit read and write access.
// - Counter write suppresses compare match on the next timer tick, both channels.
// - Each compare register is matched continuously, raising flag and, in non-pwm modes only, driving output.
// - Mask holds enables at bits 2,1,0; irq needs enable, global bit, flag.
// - Flag register holds compare b, compare a, overflow at bits 2,1,0.
// - Short I/O access decodes at data offset minus 0x20, up to 0x3F.
// - Waveform mode three bits; 0,2 non-pwm, odd codes pwm, 4,6 reserved.
// - Flags clear on vector execution or on a written one.
// - Compare output mode: 00 off, 01 toggle, 10 clear, 11 set.
module tmr_timer2 (
  input  wire logic       clk_in,          // i/o clock, 100 MHz
  input  wire logic       sys_rst_in,      // sync reset, active high
  input  wire logic [7:0] addr_in,         // register address
  input  wire logic       io_space_in,     // address is a short I/O address
  input  wire logic       wr_en_in,        // write strobe
  input  wire logic       rd_en_in,        // read strobe
  input  wire logic [7:0] wdata_in,        // write data
  input  wire logic       global_ie_in,    // cpu global interrupt bit
  input  wire logic [2:0] vector_ack_in,   // vector executed: b, a, ovf
  output logic      [7:0] rdata_out,       // read data, registered
  output logic            irq_cmp_b_out,   // compare b interrupt request
  output logic            irq_cmp_a_out,   // compare a interrupt request
  output logic            irq_ovf_out,     // overflow interrupt request
  output logic            wave_out_a,      // waveform output a
  output logic            wave_out_b       // waveform output b
);
  logic [7:0] count_q, count_d;
  logic [7:0] cmp_a_q, cmp_b_q;
  logic [7:0] ctrl_a_q;
  logic [3:0] ctrl_b_q;
  logic [2:0] mask_q;
  logic [2:0] flag_q, flag_d;
  logic [9:0] pre_q;
  logic       block_q;
  logic [7:0] rdata_q;
  logic [2:0] irq_q;
  logic       wave_a_q, wave_b_q;

  // short I/O addresses map back into data space
  wire [7:0] eff_addr = io_space_in ? (addr_in + tmr_pkg::IO_BASE) : addr_in;
  // the short window covers i/o addresses up to the top of the i/o range
  wire       io_ok    = !io_space_in || (addr_in <= tmr_pkg::IO_LAST);
  wire sel_flags = io_ok && (eff_addr == tmr_pkg::FLAGS_OFS);
  wire sel_mask  = io_ok && (eff_addr == tmr_pkg::IRQ_MASK_OFS);
  wire sel_ctl_a = io_ok && (eff_addr == tmr_pkg::CONTROL_A_OFS);
  wire sel_ctl_b = io_ok && (eff_addr == tmr_pkg::CONTROL_B_OFS);
  wire sel_cnt   = io_ok && (eff_addr == tmr_pkg::COUNT_OFS);
  wire sel_cmp_a = io_ok && (eff_addr == tmr_pkg::COMPARE_A_OFS);
  wire sel_cmp_b = io_ok && (eff_addr == tmr_pkg::COMPARE_B_OFS);

  wire [2:0] wave_mode = {ctrl_b_q[tmr_pkg::WGM_HI_BIT], ctrl_a_q[1:0]};
  wire       non_pwm   = (wave_mode == tmr_pkg::WGM_NORMAL) || (wave_mode == tmr_pkg::WGM_CLEAR_MATCH);
  wire       clr_mode  = (wave_mode == tmr_pkg::WGM_CLEAR_MATCH); // counter clears on compare a match
  wire [2:0] clk_sel   = ctrl_b_q[2:0];

  // prescaler runs freely; each tap is one cycle wide
  wire [9:0] pre_mask = (clk_sel == 3'h2) ? tmr_pkg::DIV8_MASK :
                        (clk_sel == 3'h3) ? tmr_pkg::DIV32_MASK :
                        (clk_sel == 3'h4) ? tmr_pkg::DIV64_MASK :
                        (clk_sel == 3'h5) ? tmr_pkg::DIV128_MASK :
                        (clk_sel == 3'h6) ? tmr_pkg::DIV256_MASK :
                        tmr_pkg::DIV1024_MASK;
  // code zero leaves tick low, so the counter stops
  wire tick = (clk_sel == 3'h1) ||
              ((clk_sel > 3'h1) && ((pre_q & pre_mask) == pre_mask));

  wire wr_cnt  = wr_en_in && sel_cnt;
  wire wr_ctlb = wr_en_in && sel_ctl_b;
  wire force_a = wr_ctlb && wdata_in[tmr_pkg::FOC_A_BIT];
  wire force_b = wr_ctlb && wdata_in[tmr_pkg::FOC_B_BIT];
  wire match_a, match_b;
  wire wave_a, wave_b;

  tmr_wave_ch u_ch_a (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (tick),
    .block_in   (block_q),
    .count_in   (count_q),
    .compare_in (cmp_a_q),
    .com_in     (ctrl_a_q[7:6]),
    .non_pwm_in (non_pwm),
    .force_in   (force_a),
    .match_out  (match_a),
    .wave_out   (wave_a)
  );
  tmr_wave_ch u_ch_b (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (tick),
    .block_in   (block_q),
    .count_in   (count_q),
    .compare_in (cmp_b_q),
    .com_in     (ctrl_a_q[5:4]),
    .non_pwm_in (non_pwm),
    .force_in   (force_b),
    .match_out  (match_b),
    .wave_out   (wave_b)
  );

  // only real matches count: forced compares never reach the flags or the clear
  wire ovf = tick && (count_q == tmr_pkg::COUNT_MAX) && !(clr_mode && match_a);
  // a counter write wins over a tick on the same edge
  always_comb begin
    count_d = count_q;
    if (wr_cnt) count_d = wdata_in;
    else if (tick && clr_mode && match_a) count_d = tmr_pkg::REG_RESET;
    else if (tick) count_d = count_q + 8'h01;
  end

  // hardware set wins over a same-cycle clear
  wire [2:0] set_ev = {match_b, match_a, ovf};
  wire [2:0] clr_w1 = (wr_en_in && sel_flags) ? wdata_in[2:0] : 3'h0;
  assign flag_d = (flag_q & ~(clr_w1 | vector_ack_in)) | set_ev;

  // unmapped addresses read as zero; force strobes are never stored
  wire [7:0] rd_mux =
    sel_flags ? {5'h00, flag_q} :
    sel_mask  ? {5'h00, mask_q} :
    sel_ctl_a ? ctrl_a_q :
    sel_ctl_b ? {4'h0, ctrl_b_q} :
    sel_cnt   ? count_q :
    sel_cmp_a ? cmp_a_q :
    sel_cmp_b ? cmp_b_q : 8'h00;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_q  <= tmr_pkg::REG_RESET;
      cmp_a_q  <= tmr_pkg::REG_RESET;
      cmp_b_q  <= tmr_pkg::REG_RESET;
      ctrl_a_q <= tmr_pkg::REG_RESET;
      ctrl_b_q <= 4'h0;
      mask_q   <= 3'h0;
      flag_q   <= 3'h0;
      pre_q    <= 10'h000;
      block_q  <= 1'b0;
      rdata_q  <= tmr_pkg::REG_RESET;
      irq_q    <= 3'h0;
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else begin
      count_q  <= count_d;
      flag_q   <= flag_d;
      pre_q    <= pre_q + 10'h001;
      // block stays armed until the next tick consumes it
      block_q  <= wr_cnt || (block_q && !tick);
      if (wr_en_in && sel_cmp_a) cmp_a_q <= wdata_in;
      if (wr_en_in && sel_cmp_b) cmp_b_q <= wdata_in;
      if (wr_en_in && sel_ctl_a) ctrl_a_q <= wdata_in;
      if (wr_ctlb) ctrl_b_q <= wdata_in[3:0];
      if (wr_en_in && sel_mask) mask_q <= wdata_in[2:0];
      if (rd_en_in) rdata_q <= rd_mux;
      // built from the next flags so a request rises with its flag
      irq_q    <= flag_d & mask_q & {3{global_ie_in}};
      wave_a_q <= wave_a;
      wave_b_q <= wave_b;
    end
  end

  assign rdata_out     = rdata_q;
  assign irq_cmp_b_out = irq_q[2];
  assign irq_cmp_a_out = irq_q[1];
  assign irq_ovf_out   = irq_q[0];
  assign wave_out_a    = wave_a_q;
  assign wave_out_b    = wave_b_q;

  a_force_no_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (force_a && !match_a && !ovf && !match_b && flag_q == 3'h0 && vector_ack_in == 3'h0) |=> flag_q == 3'h0)
    else $error("forced compare set a flag");
  // the output flop lags the mode by two edges, so pwm must have held one edge already
  a_pwm_force_dead: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!non_pwm && !$past(non_pwm)) |=> $stable(wave_a_q))
    else $error("waveform a moved in pwm mode");
  a_force_toggle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (force_a && non_pwm && ctrl_a_q[7:6] == 2'h1 && !match_a) |=> ##1 (wave_a_q != $past(wave_a_q)))
    else $error("force did not toggle output a");
  a_ctrl_read_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (rd_en_in && sel_ctl_b) |=> rdata_out[7:6] == 2'h0)
    else $error("force bits read nonzero");
  a_count_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_cnt |=> count_q == $past(wdata_in))
    else $error("counter write lost");
  a_block_match: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (block_q && tick && count_q == cmp_a_q && vector_ack_in == 3'h0 && !(wr_en_in && sel_flags))
      |=> flag_q[1] == $past(flag_q[1]))
    else $error("match after counter write");
  a_stop_code: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_sel == 3'h0 && !wr_cnt) |=> count_q == $past(count_q))
    else $error("counter moved while stopped");
  a_flag_w1c: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_en_in && sel_flags && wdata_in[1] && !match_a) |=> !flag_q[1])
    else $error("flag not cleared by write one");
  a_match_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    match_a |=> flag_q[1])
    else $error("compare a match lost");
  a_irq_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    irq_ovf_out |-> $past(mask_q[0]) && $past(global_ie_in))
    else $error("overflow irq without enable");
  a_pwm_hold_b: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!non_pwm && !$past(non_pwm)) |=> $stable(wave_b_q))
    else $error("waveform b moved in pwm mode");
  a_force_no_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (force_a && clr_mode && !tick && !wr_cnt) |=> count_q == $past(count_q))
    else $error("forced compare moved the counter");
  a_ovf_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (tick && count_q == tmr_pkg::COUNT_MAX && !clr_mode) |=> flag_q[tmr_pkg::OVF_BIT])
    else $error("overflow flag not set");
  a_io_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (rd_en_in && io_space_in && addr_in == (tmr_pkg::FLAGS_OFS - tmr_pkg::IO_BASE))
      |=> rdata_out == {5'h00, $past(flag_q)})
    else $error("flag register not seen at its short address");
  c_force: cover property (@(posedge clk_in) force_a && non_pwm);
  c_match_clear: cover property (@(posedge clk_in) tick && clr_mode && match_a);
  c_count_block: cover property (@(posedge clk_in) block_q && tick && count_q == cmp_a_q);
  c_overflow: cover property (@(posedge clk_in) ovf);
  c_div1024: cover property (@(posedge clk_in) tick && clk_sel == 3'h7);
endmodule

// ---- rtl/tmr_wave_ch.sv ----
`timescale 1ns/10ps
// one compare channel: match detection and waveform output latch
module tmr_wave_ch (
  input  wire logic       clk_in,         // i/o clock
  input  wire logic       sys_rst_in,     // sync reset, active high
  input  wire logic       tick_in,        // timer tick enable
  input  wire logic       block_in,       // counter written, block match
  input  wire logic [7:0] count_in,       // counter value
  input  wire logic [7:0] compare_in,     // compare value
  input  wire logic [1:0] com_in,         // compare output mode
  input  wire logic       non_pwm_in,     // waveform mode is non-pwm
  input  wire logic       force_in,       // force strobe written
  output logic            match_out,      // real compare match this tick
  output logic            wave_out        // waveform output
);
  logic wave_q;
  logic wave_d;
  wire  hit        = tick_in && !block_in && (count_in == compare_in);
  wire  force_eff  = force_in && non_pwm_in;
  wire  act        = (hit || force_eff) && non_pwm_in;
  always_comb begin
    wave_d = wave_q;
    if (act) begin
      unique case (tmr_pkg::tmr_com_e'(com_in))
        tmr_pkg::TMR_COM_OFF:    wave_d = wave_q;
        tmr_pkg::TMR_COM_TOGGLE: wave_d = !wave_q;
        tmr_pkg::TMR_COM_CLEAR:  wave_d = 1'b0;
        tmr_pkg::TMR_COM_SET:    wave_d = 1'b1;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) wave_q <= 1'b0;
    else wave_q <= wave_d;
  end
  assign match_out = hit;
  assign wave_out  = wave_q;
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic       clk_in, sys_rst_in, io_space_in, wr_en_in, rd_en_in, global_ie_in;
  logic [7:0] addr_in, wdata_in, rdata_out, v;
  logic [2:0] vector_ack_in;
  logic       irq_cmp_b_out, irq_cmp_a_out, irq_ovf_out, wave_out_a, wave_out_b;
  int         fails;
  int         n_compared;
  int         divs[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] offs[7] = '{8'h37, 8'h70, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4};
  logic [7:0] ctla[5] = '{8'h50, 8'h50, 8'hF0, 8'hA0, 8'h50};
  logic [7:0] fstb[5] = '{8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'h80};
  logic [1:0] exp_w[5] = '{2'h3, 2'h0, 2'h3, 2'h0, 2'h1};

  tmr_timer2 dut_u (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .addr_in       (addr_in),
    .io_space_in   (io_space_in),
    .wr_en_in      (wr_en_in),
    .rd_en_in      (rd_en_in),
    .wdata_in      (wdata_in),
    .global_ie_in  (global_ie_in),
    .vector_ack_in (vector_ack_in),
    .rdata_out     (rdata_out),
    .irq_cmp_b_out (irq_cmp_b_out),
    .irq_cmp_a_out (irq_cmp_a_out),
    .irq_ovf_out   (irq_ovf_out),
    .wave_out_a    (wave_out_a),
    .wave_out_b    (wave_out_b)
  );

  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'h0);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    io_space_in <= io;
    wr_en_in <= 1'h1;
    @(posedge clk_in);
    wr_en_in <= 1'h0;
  endtask

  task automatic rd_raw(input logic [7:0] a, input logic io, output logic [7:0] got);
    @(posedge clk_in);
    addr_in <= a;
    io_space_in <= io;
    rd_en_in <= 1'h1;
    @(posedge clk_in);
    rd_en_in <= 1'h0;
    #1;
    got = rdata_out;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic io = 1'h0);
    logic [7:0] got;
    rd_raw(a, io, got);
    chk(got, exp);
  endtask

  // outputs are registered twice after the strobe, so three edges is a safe settle
  task automatic wave(input logic [1:0] exp);
    repeat (3) @(posedge clk_in);
    #1;
    chk({6'h00, wave_out_b, wave_out_a}, {6'h00, exp});
  endtask

  task automatic irqs(input logic [2:0] exp);
    repeat (2) @(posedge clk_in);
    #1;
    chk({5'h00, irq_cmp_b_out, irq_cmp_a_out, irq_ovf_out}, {5'h00, exp});
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    test_done();
  end

  initial begin
    fails = 0;
    n_compared = 0;
    {sys_rst_in, io_space_in, wr_en_in, rd_en_in, global_ie_in} = 5'h10;
    {addr_in, wdata_in, vector_ack_in} = 19'h00000;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    foreach (offs[i]) rd(offs[i], 8'h00);
    irqs(3'h0);
    $display("test reset done");
    wr(8'hB3, 8'hA5);
    rd(8'hB3, 8'hA5);
    wr(8'hB4, 8'h5A);
    rd(8'hB4, 8'h5A);
    wr(8'hB2, 8'h3C);
    rd(8'hB2, 8'h3C);
    wr(8'h70, 8'h07);
    rd(8'h70, 8'h07);
    wr(8'hB5, 8'hFF);
    rd(8'hB5, 8'h00);
    rd(8'h92, 8'h00, 1'h1);
    rd(8'h17, 8'h00, 1'h1);
    wr(8'hB1, 8'hCF);
    rd(8'hB1, 8'h0F);
    wr(8'hB1, 8'h00);
    $display("test registers done");
    foreach (ctla[i]) begin
      wr(8'hB0, ctla[i]);
      wr(8'hB1, fstb[i]);
      wave(exp_w[i]);
    end
    rd(8'h37, 8'h00);
    wr(8'hB0, 8'h53);
    wr(8'hB1, 8'h00);
    // both strobes written in pwm on purpose, to show that they have no effect
    wr(8'hB1, 8'hC0);
    wave(2'h1);
    // clear-on-match with compare a equal to the count: a forced match must leave the counter alone
    wr(8'hB3, 8'h3C);
    wr(8'hB2, 8'h3C);
    wr(8'hB0, 8'h52);
    wr(8'hB1, 8'h80);
    wave(2'h0);
    rd(8'hB2, 8'h3C);
    rd(8'h37, 8'h00);
    $display("test force done");
    wr(8'hB0, 8'h00);
    @(posedge clk_in);
    global_ie_in <= 1'h1;
    foreach (offs[i]) if (i < 2) begin
      v = (i == 0) ? 8'h10 : 8'h0F;
      wr(8'h37, 8'h07);
      wr(8'hB3, 8'h10);
      wr(8'hB4, 8'h10);
      wr(8'hB2, v);
      wr(8'hB1, 8'h01);
      repeat (2) @(posedge clk_in);
      wr(8'hB1, 8'h00);
      rd(8'h37, (i == 0) ? 8'h00 : 8'h06);
    end
    irqs(3'h6);
    @(posedge clk_in);
    global_ie_in <= 1'h0;
    irqs(3'h0);
    @(posedge clk_in);
    vector_ack_in <= 3'h2;
    @(posedge clk_in);
    vector_ack_in <= 3'h0;
    rd(8'h37, 8'h04);
    wr(8'h17, 8'h04, 1'h1);
    rd(8'h37, 8'h00);
    wr(8'hB2, 8'hFE);
    wr(8'hB1, 8'h01);
    repeat (4) @(posedge clk_in);
    wr(8'hB1, 8'h00);
    rd(8'h17, 8'h01, 1'h1);
    @(posedge clk_in);
    global_ie_in <= 1'h1;
    irqs(3'h1);
    // clear-on-match wraps the count at compare a: six ticks from zero end at two
    wr(8'hB0, 8'h02);
    wr(8'h37, 8'h07);
    wr(8'hB3, 8'h03);
    wr(8'hB2, 8'h00);
    wr(8'hB1, 8'h01);
    repeat (4) @(posedge clk_in);
    wr(8'hB1, 8'h00);
    rd(8'hB2, 8'h02);
    rd(8'h37, 8'h02);
    wr(8'hB0, 8'h00);
    $display("test match done");
    foreach (divs[c]) begin
      // counter is loaded while stopped, then the clock select starts it
      wr(8'hB2, 8'h00);
      wr(8'hB1, 8'(c));
      repeat (4 * divs[c]) @(posedge clk_in);
      wr(8'hB1, 8'h00);
      rd_raw(8'hB2, 1'h0, v);
      if (c == 0)
        chk(v, 8'h00);
      else
        chk({7'h00, (v >= 8'h04 && v <= 8'(5 + 4 / divs[c]))}, 8'h01);
    end
    $display("test prescaler done");
    test_done();
  end
endmodule
